// ---- rtl/spa_cfg_defs.svh ----
// Register offsets, field positions and reset values of the stream port config block
`ifndef SPA_CFG_DEFS_SVH
`define SPA_CFG_DEFS_SVH
`define SPA_OFS_CFG0 12'h080
`define SPA_OFS_CFG1 12'h084
`define SPA_OFS_FLAGS 12'h088
`define SPA_OFS_PKT_CTRL 12'h0b0
`define SPA_BIT_PORT_EN 30
`define SPA_BIT_RELEASE 11
`define SPA_BIT_BYTE_ORDER 10
`define SPA_BIT_SER_ORDER 9
`define SPA_BIT_SER_OP 8
`define SPA_BIT_RX_MULTI 14
`define SPA_BIT_TX_MULTI 12
`define SPA_BIT_INS_DONE 8
`define SPA_BIT_OVERFLOW 0
`define SPA_CFG0_WMASK 32'h4000_7fff
`define SPA_CFG1_WMASK 32'h0000_5fff
`define SPA_MAP_RESET 8'h03
`define SPA_SYNC_C 2'h2
`endif

// ---- rtl/spa_cfg_pkg.sv ----
// Types of the stream port config block
package spa_cfg_pkg;
  typedef enum logic [1:0] {SPA_REL_IDLE, SPA_REL_VALID, SPA_REL_DUE, SPA_REL_GO} spa_rel_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spa_byte_t;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic [2:0] buf_sel;
  } spa_word_t;
endpackage

// ---- rtl/spa_cfg.sv ----
// Stream port config/status registers, release sequencer and byte/bit assembly
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "spa_cfg_defs.svh"
// Operation
// - Release mode holds frame output until valid, due, release, enable occur in order
// - Empty buffer returns the release sequence to its start
// - Byte order 0: first port byte is quadlet MSB
// - Byte order 1: first port byte is quadlet LSB
// - Serial order 0: first bit is byte MSB, 0101.. gives 0x55
// - Serial bit order ignored in 8-bit parallel mode
// - Serial mode uses data line zero only, but the output path still shifts whole bytes onto port_data_out
// - Buffer attach map, bit n attaches buffer n, reset value 3
// - Rx multi-buffer selects output buffer by port address bus, else map
// - Tx multi-buffer selects input buffer by port address bus, else map
// - Block size field applies for sync schemes A and B only
// - Insertion sets done flag and disables insertion hardware
// - Input overfill with data loss sets overflow flag
// - Reserved bits ignore writes and read zero
// - Port enable bit 0 ignores all port signalling, but rx_buf_sel still follows port_addr in Rx multi-buffer mode
module spa_cfg
  import spa_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_valid_signal,
  input wire logic port_enable_input,
  input wire logic frame_release_input,
  input wire logic [7:0] port_data_in,
  input wire logic port_strobe,
  input wire logic [2:0] port_addr,
  input wire logic insert_event,
  input wire logic overfill_event,
  input wire logic buffer_empty,
  input wire logic [1:0] sync_scheme,
  input wire logic [31:0] out_quadlet,
  input wire logic out_load,
  output logic frame_due_output,
  input wire logic frame_expired,
  output logic release_ok,
  output logic [31:0] in_quadlet,
  output logic in_quadlet_valid,
  output logic [2:0] tx_buf_sel,
  output logic [2:0] rx_buf_sel,
  output logic [7:0] port_data_out,
  output logic insert_enable,
  output logic [11:0] block_size
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] spa_first_buf(input logic [7:0] map);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (map[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] spa_swap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [12:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  logic [12:0] pin_raw;
  logic [12:0] pin_d;
  assign pin_raw = {port_valid_signal, port_enable_input, frame_release_input, frame_expired,
                    port_strobe, port_data_in};
  always_comb
  begin
    pin_d = pin_q;
    for (int i = 0; i < 13; i++)
    begin
      if (pin_s2_q[i] == pin_s3_q[i])
      begin
        pin_d[i] = pin_s3_q[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q <= 13'h0000;
      pin_s2_q <= 13'h0000;
      pin_s3_q <= 13'h0000;
      pin_q <= 13'h0000;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= pin_d;
    end
  end
  logic s_valid, s_en, s_rel, s_exp, s_stb;
  logic [7:0] s_data;
  assign {s_valid, s_en, s_rel, s_exp, s_stb, s_data} = pin_q;

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] cfg0_q, cfg0_d, cfg1_q, cfg1_d;
  logic [1:0] flags_q, flags_d;
  logic ins_en_q, ins_en_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic setup, wr, rd, hit;
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_q && pwrite;
  assign rd = psel && penable && pready_q && !pwrite;
  assign hit = (paddr == `SPA_OFS_CFG0) || (paddr == `SPA_OFS_CFG1) ||
               (paddr == `SPA_OFS_FLAGS) || (paddr == `SPA_OFS_PKT_CTRL);
  logic port_on, ser_mode, ser_rev, byte_rev;
  assign port_on = cfg0_q[`SPA_BIT_PORT_EN];
  assign ser_mode = cfg0_q[`SPA_BIT_SER_OP];
  assign ser_rev = cfg0_q[`SPA_BIT_SER_ORDER];
  assign byte_rev = cfg0_q[`SPA_BIT_BYTE_ORDER];
  logic ovf_evt;

  always_comb
  begin
    cfg0_d = cfg0_q;
    cfg1_d = cfg1_q;
    flags_d = flags_q;
    ins_en_d = ins_en_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (setup)
    begin
      pready_d = 1'b1;
      pslverr_d = !hit;
      prdata_d = 32'h0000_0000;
      case (paddr)
        `SPA_OFS_CFG0: prdata_d = cfg0_q;
        `SPA_OFS_CFG1: prdata_d = cfg1_q;
        `SPA_OFS_FLAGS: prdata_d = {23'h000000, flags_q[1], 7'h00, flags_q[0]};
        `SPA_OFS_PKT_CTRL: prdata_d = {31'h00000000, ins_en_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (wr && paddr == `SPA_OFS_CFG0)
    begin
      cfg0_d = pwdata & `SPA_CFG0_WMASK;
    end
    if (wr && paddr == `SPA_OFS_CFG1)
    begin
      cfg1_d = pwdata & `SPA_CFG1_WMASK;
    end
    if (wr && paddr == `SPA_OFS_PKT_CTRL)
    begin
      ins_en_d = pwdata[0];
    end
    if (rd && paddr == `SPA_OFS_FLAGS)
    begin
      flags_d = 2'h0;
    end
    if (insert_event && ins_en_q)
    begin
      flags_d[1] = 1'b1;
      ins_en_d = 1'b0;
    end
    if (ovf_evt)
    begin
      flags_d[0] = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg0_q <= {24'h000000, `SPA_MAP_RESET};
      cfg1_q <= 32'h0000_0000;
      flags_q <= 2'h0;
      ins_en_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      cfg0_q <= cfg0_d;
      cfg1_q <= cfg1_d;
      flags_q <= flags_d;
      ins_en_q <= ins_en_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************
  // Release sequencer
  // ****************************************
  spa_rel_t rel_q, rel_d;
  logic due_q, due_d, ok_q, ok_d;
  always_comb
  begin
    rel_d = rel_q;
    due_d = due_q;
    case (rel_q)
      SPA_REL_IDLE: if (s_valid) rel_d = SPA_REL_VALID;
      SPA_REL_VALID:
      begin
        if (s_exp)
        begin
          due_d = 1'b1;
          rel_d = SPA_REL_DUE;
        end
      end
      SPA_REL_DUE: if (s_rel) rel_d = SPA_REL_GO;
      SPA_REL_GO: rel_d = SPA_REL_GO;
      default: rel_d = SPA_REL_IDLE;
    endcase
    if (buffer_empty || !port_on)
    begin
      rel_d = SPA_REL_IDLE;
      due_d = 1'b0;
    end
    ok_d = port_on && (!cfg0_q[`SPA_BIT_RELEASE] || (rel_q == SPA_REL_GO && s_en));
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rel_q <= SPA_REL_IDLE;
      due_q <= 1'b0;
      ok_q <= 1'b0;
    end
    else
    begin
      rel_q <= rel_d;
      due_q <= due_d;
      ok_q <= ok_d;
    end
  end

  // ****************************************
  // Input assembly
  // ****************************************
  logic [31:0] asm_q, asm_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] bits_q, bits_d;
  spa_word_t word_q, word_d;
  logic stb_q, stb_d;
  logic [7:0] nbyte;
  logic byte_rdy;
  always_comb
  begin
    asm_d = asm_q;
    cnt_d = cnt_q;
    bits_d = bits_q;
    word_d = word_q;
    word_d.valid = 1'b0;
    stb_d = s_stb;
    ovf_evt = 1'b0;
    nbyte = s_data;
    byte_rdy = 1'b0;
    if (port_on && s_stb && !stb_q)
    begin
      if (ser_mode)
      begin
        nbyte = ser_rev ? {s_data[0], bits_q[7:1]} : {bits_q[6:0], s_data[0]};
        bits_d = nbyte;
        byte_rdy = (cnt_q[2:0] == 3'h7);
        cnt_d = cnt_q + 5'h01;
      end
      else
      begin
        byte_rdy = 1'b1;
        cnt_d = cnt_q + 5'h08;
      end
      if (byte_rdy)
      begin
        asm_d = byte_rev ? {nbyte, asm_q[31:8]} : {asm_q[23:0], nbyte};
        if (cnt_q[4:3] == 2'h3 && (ser_mode ? cnt_q[2:0] == 3'h7 : 1'b1))
        begin
          if (word_q.valid)
          begin
            ovf_evt = 1'b1;
          end
          word_d.valid = 1'b1;
          word_d.data = asm_d;
          word_d.buf_sel = cfg1_q[`SPA_BIT_TX_MULTI] ? port_addr : spa_first_buf(cfg0_q[7:0]);
          cnt_d = 5'h00;
        end
      end
    end
    if (!port_on)
    begin
      cnt_d = 5'h00;
    end
    ovf_evt = ovf_evt || (port_on && overfill_event);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      asm_q <= 32'h0000_0000;
      cnt_q <= 5'h00;
      bits_q <= 8'h00;
      word_q <= '0;
      stb_q <= 1'b0;
    end
    else
    begin
      asm_q <= asm_d;
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      word_q <= word_d;
      stb_q <= stb_d;
    end
  end

  // ****************************************
  // Output path
  // ****************************************
  logic [31:0] oq_q, oq_d;
  logic [2:0] rxs_q, rxs_d;
  logic [11:0] bs_q, bs_d;
  always_comb
  begin
    oq_d = oq_q;
    if (out_load && ok_q)
    begin
      oq_d = byte_rev ? out_quadlet : spa_swap(out_quadlet);
    end
    else if (port_on && s_stb && !stb_q && ok_q)
    begin
      oq_d = {8'h00, oq_q[31:8]};
    end
    rxs_d = cfg1_q[`SPA_BIT_RX_MULTI] ? port_addr : spa_first_buf(cfg0_q[7:0]);
    bs_d = (sync_scheme == `SPA_SYNC_C) ? 12'h000 : cfg1_q[11:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oq_q <= 32'h0000_0000;
      rxs_q <= 3'h0;
      bs_q <= 12'h000;
    end
    else
    begin
      oq_q <= oq_d;
      rxs_q <= rxs_d;
      bs_q <= bs_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign frame_due_output = due_q;
  assign release_ok = ok_q;
  assign in_quadlet = word_q.data;
  assign in_quadlet_valid = word_q.valid;
  assign tx_buf_sel = word_q.buf_sel;
  assign rx_buf_sel = rxs_q;
  assign port_data_out = oq_q[7:0];
  assign insert_enable = ins_en_q;
  assign block_size = bs_q;
endmodule
`default_nettype wire

// ---- test/spa_cfg_properties.sv ----
// Assertions for the stream port config block and their binding
`timescale 1ns/100ps
`default_nettype none
module spa_cfg_properties
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic release_ok,
  input wire logic frame_due_output,
  input wire logic buffer_empty,
  input wire logic in_quadlet_valid,
  input wire logic insert_event,
  input wire logic insert_enable,
  input wire logic [1:0] sync_scheme,
  input wire logic [11:0] block_size
);
  // ****
  // Shadow of enable and release bits
  // ****
  logic en_q, en_d, rel_q, rel_d, due_q, due_d, wr0;
  logic [3:0] dis_q, dis_d;
  assign wr0 = psel && penable && pready && pwrite && paddr == 12'h080;
  always_comb
  begin
    en_d = wr0 ? pwdata[30] : en_q;
    rel_d = wr0 ? pwdata[11] : rel_q;
    due_d = (due_q || frame_due_output) && !buffer_empty && en_q;
    dis_d = en_q ? 4'h0 : dis_q + {3'h0, dis_q != 4'hf};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {en_q, rel_q, due_q, dis_q} <= 7'h00;
    else
      {en_q, rel_q, due_q, dis_q} <= {en_d, rel_d, due_d, dis_d};
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_sync_c;
    (sync_scheme == 2'h2) [*2];
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_unmapped: assert property
    (pready |-> pslverr == !(paddr inside {12'h080, 12'h084, 12'h088, 12'h0b0}))
    else $error("pslverr wrong");
  a_insert_off: assert property (insert_event |=> !insert_enable)
    else $error("insertion still enabled");
  a_block_sync_c: assert property (s_sync_c |-> block_size == 12'h000)
    else $error("block size under scheme C");
  a_idle_port: assert property (dis_q > 4'h7 |-> !in_quadlet_valid)
    else $error("word while disabled");
  a_release_gate: assert property
    ($rose(release_ok) && rel_q |-> due_q || frame_due_output)
    else $error("release before due");
  a_empty_restart: assert property (buffer_empty && rel_q |-> ##[1:3] !release_ok)
    else $error("release kept after empty");
endmodule
bind spa_cfg spa_cfg_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .release_ok, .frame_due_output, .buffer_empty,
  .in_quadlet_valid, .insert_event, .insert_enable, .sync_scheme, .block_size);
`default_nettype wire

// ---- test/spa_app_model.sv ----
// Application-side model driving the stream port pins
`timescale 1ns/100ps
`default_nettype none
module spa_app_model
(
  input wire logic pclk,
  input wire logic frame_due_output,
  output logic port_valid_signal,
  output logic port_enable_input,
  output logic frame_release_input,
  output logic port_strobe,
  output logic [7:0] port_data_in
);
  // ****
  // Pin sequencing
  // ****
  initial
  begin
    {port_valid_signal, port_enable_input, frame_release_input, port_strobe} = 4'h0;
    port_data_in = 8'h5a;
  end
  task pins(input logic v, input logic e);
    @(posedge pclk);
    port_valid_signal <= v;
    port_enable_input <= e;
    frame_release_input <= 1'b0;
  endtask
  task put(input logic [7:0] v);
    @(posedge pclk);
    port_data_in <= v;
    repeat (5) @(posedge pclk);
    port_strobe <= 1'b1;
    repeat (6) @(posedge pclk);
    port_strobe <= 1'b0;
    port_data_in <= ~v;
    repeat (6) @(posedge pclk);
  endtask
  task grant;
    for (int n = 0; n < 100 && frame_due_output !== 1'b1; n++) @(negedge pclk);
    @(posedge pclk);
    frame_release_input <= 1'b1;
    repeat (6) @(posedge pclk);
    port_enable_input <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- test/stream_port_a_config_status_test.sv ----
// Self-checking bench for the stream port config block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, x, g) begin checked++; if ((g) !== (x)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, x, g); end end
module stream_port_a_config_status_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic out_load = 1'b0, insert_event = 1'b0, overfill_event = 1'b0, buffer_empty = 1'b0;
  logic frame_expired = 1'b0, pready, pslverr, port_valid_signal, port_enable_input;
  logic frame_release_input, port_strobe, frame_due_output, release_ok, in_quadlet_valid;
  logic insert_enable, e;
  logic [1:0] sync_scheme = 2'h0;
  logic [2:0] port_addr = 3'h0, tx_buf_sel, rx_buf_sel;
  logic [7:0] port_data_in, port_data_out, b;
  logic [11:0] paddr = 12'h000, block_size;
  logic [31:0] pwdata = 32'h0, out_quadlet = 32'h0, prdata, in_quadlet, r, d;
  logic [11:0] ofs[2] = '{12'h080, 12'h084};
  logic [31:0] msk[2] = '{32'h4000_7fff, 32'h0000_5fff};
  logic [7:0] pat[4] = '{8'hab, 8'hcd, 8'hef, 8'h01};
  logic [31:0] got[$];
  logic [2:0] sel[$];
  int checked = 0, miscompares = 0, m, x, k, u;
  always #2.5 pclk = ~pclk;
  spa_cfg u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .port_valid_signal, .port_enable_input, .frame_release_input,
    .port_data_in, .port_strobe, .port_addr, .insert_event, .overfill_event, .buffer_empty,
    .sync_scheme, .out_quadlet, .out_load, .frame_due_output, .frame_expired, .release_ok,
    .in_quadlet, .in_quadlet_valid, .tx_buf_sel, .rx_buf_sel, .port_data_out,
    .insert_enable, .block_size);
  spa_app_model u_app (.pclk, .frame_due_output, .port_valid_signal, .port_enable_input,
    .frame_release_input, .port_strobe, .port_data_in);
  always @(negedge pclk)
    if (in_quadlet_valid === 1'b1)
    begin
      got.push_back(in_quadlet);
      sel.push_back(tx_buf_sel);
    end
  // ****
  // Bus tasks
  // ****
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    `CHK("read", v, r)
  endtask
  task clk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk(30000);
    miscompares++;
    give_verdict();
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    void'($urandom(88774));
    clk(4);
    presetn <= 1'b1;
    rd(12'h080, 32'h0000_0003);
    rd(12'h088, 32'h0);
    for (m = 0; m < 2; m++)
    begin
      d = $urandom;
      wr(ofs[m], d);
      rd(ofs[m], d & msk[m]);
    end
    apb(1'b0, 12'h0c0, 32'h0);
    `CHK("error", 1'b1, e)
    `CHK("unmapped", 32'h0, r)
    sync_scheme <= 2'($urandom_range(1));
    wr(12'h084, 32'h0000_0abc);
    clk(3);
    `CHK("block", 12'habc, block_size)
    sync_scheme <= 2'h2;
    clk(3);
    `CHK("block", 12'h000, block_size)
    u_app.pins(1'b1, 1'b1);
    for (m = 0; m < 4; m++)
    begin
      port_addr <= 3'($urandom);
      wr(12'h084, 32'(m[0]) << 12);
      wr(12'h080, 32'h4000_000c | 32'(m[0]) << 10 | 32'(m[1]) << 8 | 32'(m[1] ? m[0] : 1) << 9);
      x = 0;
      for (int i = 0; i < (m > 1 ? 32 : 4); i++)
      begin
        u = m > 1 ? i % 2 : int'(pat[i]);
        b = 8'($urandom);
        u_app.put(m > 1 ? {b[7:1], 1'(u)} : 8'(u));
        k = m < 2 ? u : m[0] ? k >> 1 | u << 7 : (k << 1 | u) & 255;
        if (m < 2 || i % 8 == 7) x = m[0] ? x >> 8 | k << 24 : x << 8 | k;
      end
      clk(10);
      `CHK("quadlet", 32'(x), got[0])
      `CHK("tx buffer", m[0] ? port_addr : 3'h2, sel[0])
      `CHK("words", 1, got.size())
      got.delete();
      sel.delete();
    end
    wr(12'h084, 32'h0000_4000);
    port_addr <= 3'h5;
    clk(3);
    `CHK("rx buffer", 3'h5, rx_buf_sel)
    wr(12'h084, 32'h0);
    clk(3);
    `CHK("rx buffer", 3'h2, rx_buf_sel)
    wr(12'h080, 32'h0000_000c);
    for (m = 0; m < 4; m++) u_app.put(pat[m]);
    clk(10);
    `CHK("words", 0, got.size())
    wr(12'h080, 32'h4000_000c);
    overfill_event <= 1'b1;
    clk(1);
    overfill_event <= 1'b0;
    rd(12'h088, 32'h1);
    rd(12'h088, 32'h0);
    wr(12'h0b0, 32'h1);
    clk(1);
    `CHK("insert", 1'b1, insert_enable)
    insert_event <= 1'b1;
    clk(1);
    insert_event <= 1'b0;
    clk(1);
    `CHK("insert", 1'b0, insert_enable)
    rd(12'h088, 32'h100);
    rd(12'h088, 32'h0);
    wr(12'h080, 32'h4000_080c);
    u_app.pins(1'b1, 1'b0);
    clk(10);
    `CHK("release", 1'b0, release_ok)
    frame_expired <= 1'b1;
    clk(8);
    `CHK("due", 1'b1, frame_due_output)
    frame_expired <= 1'b0;
    u_app.grant();
    clk(10);
    `CHK("release", 1'b1, release_ok)
    out_quadlet <= 32'habcd_ef01;
    out_load <= 1'b1;
    clk(1);
    out_load <= 1'b0;
    clk(2);
    `CHK("out byte", 8'hab, port_data_out)
    u_app.put(8'h00);
    `CHK("out byte", 8'hcd, port_data_out)
    buffer_empty <= 1'b1;
    clk(1);
    buffer_empty <= 1'b0;
    clk(10);
    `CHK("release", 1'b0, release_ok)
    `CHK("due", 1'b0, frame_due_output)
    give_verdict();
  end
endmodule
`default_nettype wire
